// ==== core/bchr_consts.vh ====
/*
 * Constants for the bridge header register bank: byte offsets, field
 * positions and reset values. Included by the register bank module only.
 */
`ifndef BCHR_CONSTS_VH
`define BCHR_CONSTS_VH

// byte offsets of the configuration bytes
`define BCHR_OFF_PRI_LAT      8'h0D
`define BCHR_OFF_HDR_LAYOUT   8'h0E
`define BCHR_OFF_SELF_TEST    8'h0F
`define BCHR_OFF_BASE_ZERO    8'h10
`define BCHR_OFF_BASE_ONE     8'h14
`define BCHR_OFF_UP_BUS       8'h18
`define BCHR_OFF_DOWN_BUS     8'h19
`define BCHR_OFF_HIGH_BUS     8'h1A
`define BCHR_OFF_SEC_LAT      8'h1B
`define BCHR_OFF_IO_LOW       8'h1C
`define BCHR_OFF_IO_HIGH      8'h1D

// word addresses of the Wishbone map (byte address bits 7:2)
`define BCHR_WORD_0C          6'h03
`define BCHR_WORD_10          6'h04
`define BCHR_WORD_14          6'h05
`define BCHR_WORD_18          6'h06
`define BCHR_WORD_1C          6'h07
`define BCHR_WORD_CTRL        6'h20

// reset and constant values
`define BCHR_PRI_LAT_VAL      8'h00
`define BCHR_HDR_LAYOUT_VAL   8'h01
`define BCHR_SELF_TEST_VAL    8'h00
`define BCHR_BASE_ADDR_VAL    32'h0000_0000
`define BCHR_SEC_LAT_VAL      8'h00
`define BCHR_BUS_RST          8'h00
`define BCHR_IO_LOW_RST       4'hF
`define BCHR_IO_HIGH_RST      4'h0
`define BCHR_IO_CAP_RST       1'b1
`define BCHR_LOCK_RST         1'b0

// field positions inside the I/O window bytes
`define BCHR_IO_CAP_BIT       0
`define BCHR_IO_ADDR_MSB      7
`define BCHR_IO_ADDR_LSB      4

`endif

// ==== core/bchr_regs.v ====
/*
 * Bridge configuration header register bank, bytes 0x0D..0x1D, as a
 * classic Wishbone slave with an I/O window decoder for forwarding.
 * Assumes one clock CLK, synchronous active-low reset RST_B, and a
 * master that holds its request until ACK. Byte address = WB_ADR.
 */
// Local design decision: the Wishbone interface to the registers.
// Overview of operation
// RULE1: primary latency timer byte reads zero
// RULE2: header layout byte reads constant 0x01
// RULE3: self test byte reads zero
// RULE4: both base address words read zero
// RULE5: upstream bus number RW, resets zero
// RULE6: downstream bus number RW, resets zero
// RULE7: highest bus behind RW, resets zero
// RULE8: secondary latency timer byte reads zero
// RULE9: width bit: 0 narrow, 1 wide; resets 1
// RULE10: window high bit0 mirrors width bit
// RULE11: window low bits 7:4 RW, reset 0xF
// RULE12: window high bits 7:4 RW, reset 0
// RULE13: window fields steer I/O forwarding
// RULE14: bits 3:1 of window bytes read zero
// RULE15: forward when base <= addr <= limit
// RULE16: width bit writable only while unlocked
`timescale 1ns/1ps
`include "bchr_consts.vh"

module bchr_regs (
  input  wire        CLK,
  input  wire        RST_B,
  input  wire        WB_CYC_I,
  input  wire        WB_STB_I,
  input  wire        WB_WE_I,
  input  wire [7:0]  WB_ADR_I,
  input  wire [3:0]  WB_SEL_I,
  input  wire [31:0] WB_DAT_I,
  output reg  [31:0] WB_DAT_O,
  output reg         WB_ACK_O,
  input  wire        IO_REQ_VALID,
  input  wire [31:0] IO_REQ_ADDR,
  output reg         IO_FWD_VALID,
  output reg         IO_FWD_HIT,
  output reg         LOCK_ACTIVE
);

  reg  [7:0]  up_bus_q;
  reg  [7:0]  down_bus_q;
  reg  [7:0]  high_bus_q;
  reg  [3:0]  io_low_q;
  reg  [3:0]  io_high_q;
  reg         io_width_cap_q;
  reg         lock_q;
  reg  [31:0] rd_data_d;
  reg         hit_d;
  wire [5:0]  word_addr;
  wire        req;
  wire        wr_en;
  wire [7:0]  io_low_byte;
  wire [7:0]  io_high_byte;
  wire [31:0] io_base_addr;
  wire [31:0] io_limit_addr;

  assign word_addr = WB_ADR_I[7:2];
  // ack pulses one cycle; the drop after ack keeps a held request from double-acking
  assign req   = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  // write lands at the edge where the master samples ack high
  assign wr_en = WB_CYC_I & WB_STB_I & WB_ACK_O & WB_WE_I;

  assign io_low_byte  = {io_low_q, 3'b000, io_width_cap_q};  // [RULE14]
  assign io_high_byte = {io_high_q, 3'b000, io_width_cap_q}; // [RULE10] [RULE14]

  // read mux; unmapped words read zero and still ack
  always @* begin
    rd_data_d = 32'h0000_0000;
    case (word_addr)
      `BCHR_WORD_0C: begin
        rd_data_d = {`BCHR_SELF_TEST_VAL, `BCHR_HDR_LAYOUT_VAL,
                     `BCHR_PRI_LAT_VAL, 8'h00}; // [RULE1] [RULE2] [RULE3]
      end
      `BCHR_WORD_10: rd_data_d = `BCHR_BASE_ADDR_VAL; // [RULE4]
      `BCHR_WORD_14: rd_data_d = `BCHR_BASE_ADDR_VAL; // [RULE4]
      `BCHR_WORD_18: begin
        rd_data_d = {`BCHR_SEC_LAT_VAL, high_bus_q, down_bus_q, up_bus_q}; // [RULE8]
      end
      `BCHR_WORD_1C: rd_data_d = {16'h0000, io_high_byte, io_low_byte};
      `BCHR_WORD_CTRL: rd_data_d = {31'h0000_0000, lock_q};
      default: rd_data_d = 32'h0000_0000;
    endcase
  end

  always @(posedge CLK) begin
    if (!RST_B) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= req;
      WB_DAT_O <= (req & ~WB_WE_I) ? rd_data_d : 32'h0000_0000;
    end
  end

  // writable fields; read-only bytes simply ignore writes
  always @(posedge CLK) begin
    if (!RST_B) begin
      up_bus_q       <= `BCHR_BUS_RST;      // [RULE5]
      down_bus_q     <= `BCHR_BUS_RST;      // [RULE6]
      high_bus_q     <= `BCHR_BUS_RST;      // [RULE7]
      io_low_q       <= `BCHR_IO_LOW_RST;   // [RULE11]
      io_high_q      <= `BCHR_IO_HIGH_RST;  // [RULE12]
      io_width_cap_q <= `BCHR_IO_CAP_RST;   // [RULE9]
      lock_q         <= `BCHR_LOCK_RST;
    end else if (wr_en) begin
      if (word_addr == `BCHR_WORD_18) begin
        if (WB_SEL_I[0]) up_bus_q   <= WB_DAT_I[7:0];   // [RULE5]
        if (WB_SEL_I[1]) down_bus_q <= WB_DAT_I[15:8];  // [RULE6]
        if (WB_SEL_I[2]) high_bus_q <= WB_DAT_I[23:16]; // [RULE7]
      end
      if (word_addr == `BCHR_WORD_1C) begin
        if (WB_SEL_I[0]) begin
          io_low_q <= WB_DAT_I[`BCHR_IO_ADDR_MSB:`BCHR_IO_ADDR_LSB]; // [RULE11]
          if (!lock_q) io_width_cap_q <= WB_DAT_I[`BCHR_IO_CAP_BIT]; // [RULE16] [RULE9]
        end
        if (WB_SEL_I[1]) io_high_q <= WB_DAT_I[15:12]; // [RULE12]
      end
      // lock is software owned; once set only reset or a write of 0 frees it
      if (word_addr == `BCHR_WORD_CTRL && WB_SEL_I[0]) lock_q <= WB_DAT_I[0];
    end
  end

  // narrow addressing compares only the low 16 bits; upper bits must be zero
  assign io_base_addr  = {16'h0000, io_low_q, 12'h000};
  assign io_limit_addr = {16'h0000, io_high_q, 12'hFFF};

  always @* begin
    hit_d = (IO_REQ_ADDR >= io_base_addr) && (IO_REQ_ADDR <= io_limit_addr); // [RULE15]
    if (!io_width_cap_q && (IO_REQ_ADDR[31:16] != 16'h0000)) hit_d = 1'b0;
  end

  // one-cycle registered decision per request
  always @(posedge CLK) begin
    if (!RST_B) begin
      IO_FWD_VALID <= 1'b0;
      IO_FWD_HIT   <= 1'b0;
      LOCK_ACTIVE  <= 1'b0;
    end else begin
      IO_FWD_VALID <= IO_REQ_VALID;
      IO_FWD_HIT   <= IO_REQ_VALID & hit_d; // [RULE13]
      LOCK_ACTIVE  <= lock_q;
    end
  end

endmodule // bchr_regs

// ==== dv/bchr_regs_properties.sv ====
/* port checker for bchr_regs; bound to every instance of it */
`timescale 1ns/1ps
module bchr_regs_chk (
  input wire        CLK, RST_B, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O,
  input wire        IO_REQ_VALID, IO_FWD_VALID, IO_FWD_HIT, LOCK_ACTIVE,
  input wire [7:0]  WB_ADR_I,
  input wire [3:0]  WB_SEL_I,
  input wire [31:0] WB_DAT_I, WB_DAT_O, IO_REQ_ADDR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  wire       rd = WB_ACK_O && !WB_WE_I;
  wire [5:0] wd = WB_ADR_I[7:2];
  sequence s_take; WB_CYC_I && WB_STB_I && !WB_ACK_O; endsequence
  sequence s_answer; WB_ACK_O ##1 !WB_ACK_O; endsequence
  a_ack_once: assert property (s_take |=> s_answer)
    else $error("ack not a single pulse after request");
  a_dat_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
    else $error("read data not zero outside ack");
  a_hdr_word: assert property (rd && wd == 6'h03 |-> WB_DAT_O == 32'h0001_0000)
    else $error("header word wrong");
  a_base_zero: assert property (rd && (wd == 6'h04 || wd == 6'h05) |-> WB_DAT_O == 32'h0)
    else $error("base address word not zero");
  a_bus_top: assert property (rd && wd == 6'h06 |-> WB_DAT_O[31:24] == 8'h00)
    else $error("secondary latency byte not zero");
  a_io_resv: assert property (rd && wd == 6'h07 |-> WB_DAT_O[31:16] == 16'h0 &&
    WB_DAT_O[3:1] == 3'h0 && WB_DAT_O[11:9] == 3'h0 && WB_DAT_O[8] == WB_DAT_O[0])
    else $error("window word reserved or mirror bits wrong");
  a_fwd_follow: assert property (1'b1 |=> IO_FWD_VALID == $past(IO_REQ_VALID))
    else $error("forward valid not one cycle after request");
  a_lock_set: assert property (WB_ACK_O && WB_WE_I && WB_ADR_I == 8'h80 && WB_SEL_I[0] &&
    WB_DAT_I[0] |-> ##[1:2] LOCK_ACTIVE) else $error("lock not raised");
endmodule // bchr_regs_chk

bind bchr_regs bchr_regs_chk i_chk (.*);

// ==== dv/bchr_regs_tb.sv ====
/* self-checking bench for bchr_regs; drives Wishbone and the I/O decode port */
`timescale 1ns/1ps
module bchr_regs_tb;
  reg         clk = 0, rst_b = 0, cyc = 0, stb = 0, we = 0, io_v = 0;
  reg [7:0]   adr = 0;
  reg [3:0]   sel = 0, lo, hi;
  reg [31:0]  dat = 0, io_a = 0, r, d;
  wire [31:0] dout;
  wire        ack, fv, fh, lk;
  integer     fails = 0, total_checks = 0, i;
  always #12.5 clk = ~clk;
  bchr_regs i_dut (.CLK(clk), .RST_B(rst_b), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dout), .WB_ACK_O(ack),
    .IO_REQ_VALID(io_v), .IO_REQ_ADDR(io_a), .IO_FWD_VALID(fv), .IO_FWD_HIT(fh),
    .LOCK_ACTIVE(lk));
  function [31:0] io_word(input [3:0] l, input [3:0] h, input c);
    io_word = {16'h0, h, 3'h0, c, l, 3'h0, c};
  endfunction
  function hit(input [31:0] a, input [3:0] l, input [3:0] h);
    hit = a[31:16] == 16'h0 && a[15:12] >= l && a[15:12] <= h;
  endfunction
  task chk(input string n, input [31:0] e, input [31:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("[ERR] %s exp %h got %h", n, e, g);
      end
    end
  endtask
  // holds the request until ack; the bounded wait only guards a hang
  task wb(input w, input [7:0] a, input [31:0] v);
    integer n;
    begin
      cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= v; sel <= 4'hF; n = 0;
      do begin @(posedge clk); n = n + 1; end while (ack !== 1'b1 && n < 20);
      if (n >= 20) fails = fails + 1;
      r = dout; cyc <= 0; stb <= 0;
      @(posedge clk);
    end
  endtask
  task test_done;
    begin
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin #100000; fails = fails + 1; test_done; end
  initial begin
    i = $urandom(52584);
    repeat (12) @(posedge clk);
    rst_b <= 1;
    @(posedge clk);
    wb(0, 8'h18, 0); chk("bus_rst", 32'h0, r);
    wb(0, 8'h1C, 0); chk("io_rst", 32'h0000_01F1, r);
    for (i = 0; i < 4; i = i + 1) begin
      d = (i == 3) ? 32'h40 : 32'h0C + 4 * i;
      wb(1, d[7:0], 32'hFFFF_FFFF);
      wb(0, d[7:0], 0); chk("ro_word", (i == 0) ? 32'h0001_0000 : 32'h0, r);
    end
    d = $urandom;
    wb(1, 8'h18, d);
    wb(0, 8'h18, 0); chk("bus_rw", {8'h0, d[23:0]}, r);
    wb(1, 8'h1C, d);
    wb(0, 8'h1C, 0); chk("io_rw", io_word(d[7:4], d[15:12], d[0]), r);
    $display("register tests done");
    wb(1, 8'h80, 1);
    @(posedge clk);
    chk("lock", 1, lk);
    wb(1, 8'h1C, ~d);
    wb(0, 8'h1C, 0); chk("io_lock", io_word(~d[7:4], ~d[15:12], d[0]), r);
    wb(1, 8'h80, 0);
    $display("lock test done");
    lo = $urandom % 8;
    hi = lo + $urandom % 8;
    wb(1, 8'h1C, {16'h0, hi, 4'h0, lo, 4'h1});
    for (i = 0; i < 30; i = i + 1) begin
      io_a <= (i == 0) ? {16'h0, lo, 12'h000} : (i == 1) ? {16'h0, hi, 12'hFFF} : $urandom & 32'h1FFFF;
      io_v <= 1;
      @(posedge clk);
      io_v <= 0;
      @(posedge clk);
      chk("fwd_valid", 1, fv);
      chk("fwd_hit", hit(io_a, lo, hi), fh);
      @(posedge clk);
    end
    $display("decode test done");
    test_done;
  end
endmodule // bchr_regs_tb
